// ### core/led_driver_status_flags.sv
// Purpose: read-only status bank plus password gate of the led driver
// Assumes: byte register port from the serial bus decoder, same clock
// Notes:   read data is registered, one cycle after rd_en
`timescale 1ns/10ps
`default_nettype none
module led_driver_status_flags
  import status_flags_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [7:0]           reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 failsafe_input_pin,
  input  wire logic                 ref_fault,
  input  wire logic                 failsafe_mode,
  input  wire logic                 channel_fault,
  input  wire logic                 overtemp_shutdown,
  input  wire logic                 overtemp_warning,
  input  wire logic                 crc_fault,
  input  wire logic                 eeprom_prog_done,
  input  wire logic                 eeprom_prog_start,
  input  wire logic                 adc_done,
  input  wire logic [7:0]           adc_result,
  input  wire logic                 adc_is_supply,
  input  wire logic                 supply_below_thr,
  input  wire logic                 diag_start,
  input  wire logic                 diag_done,
  input  wire logic [CHANNELS-1:0]  diag_open,
  input  wire logic [CHANNELS-1:0]  diag_short,
  input  wire logic [CHANNELS-1:0]  diag_single_short,
  output logic                      conversion_start,
  output logic [ADC_SEL_W-1:0]      conversion_channel_select,
  output logic [7:0]                eeprom_password_value
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic wr_clear   = wr_en && (reg_addr == OFF_CLEAR_CTRL);
  wire logic clear_por  = wr_clear && reg_wdata[POR_CLEAR_BIT];
  wire logic wr_adcsel  = wr_en && (reg_addr == OFF_ADC_SELECT);
  wire logic wr_pass    = wr_en && (reg_addr == OFF_PASSWORD);
  wire logic rd_conv    = rd_en && (reg_addr == OFF_CONV_RES);
  wire logic [CHANNELS-1:0] diag_any = diag_open | diag_short | diag_single_short;

  // ----------------------------------------
  // pin and flags
  // ----------------------------------------
  logic pin_level;
  pin_sync u_pin (
    .clk   (clk),
    .reset (reset),
    .din   (failsafe_input_pin),
    .dout  (pin_level)
  );

  logic por_flag;
  logic done_flag;
  logic prog_flag;
  logic od_flag;
  logic [CHANNELS-1:0] diag_flag;

  // por flag: only cleared by the clear-por write
  sticky_bit #(.RST_VAL(1'b1)) u_por (
    .clk   (clk),
    .reset (reset),
    .set   (1'b0),
    .clear (clear_por),
    .q     (por_flag)
  );

  // a result arriving with the read keeps the flag set
  sticky_bit #(.RST_VAL(1'b0)) u_done (
    .clk   (clk),
    .reset (reset),
    .set   (adc_done),
    .clear (rd_conv),
    .q     (done_flag)
  );

  sticky_bit #(.RST_VAL(1'b0)) u_prog (
    .clk   (clk),
    .reset (reset),
    .set   (eeprom_prog_done),
    .clear (eeprom_prog_start),
    .q     (prog_flag)
  );

  sticky_bit #(.RST_VAL(1'b0)) u_od (
    .clk   (clk),
    .reset (reset),
    .set   (diag_done),
    .clear (diag_start),
    .q     (od_flag)
  );

  // channel flags clear when a new diagnostic run starts
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_diag
      sticky_bit #(.RST_VAL(1'b0)) u_ch (
        .clk   (clk),
        .reset (reset),
        .set   (diag_any[g]),
        .clear (diag_start),
        .q     (diag_flag[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // live flags and results
  // ----------------------------------------
  logic ref_r;
  logic safe_r;
  logic out_r;
  logic tsd_r;
  logic pre_r;
  logic crc_r;
  logic low_r;
  logic [7:0] supply_r;
  logic [7:0] conv_r;
  logic [7:0] pass_r;
  logic [ADC_SEL_W-1:0] sel_r;
  logic start_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_r <= 1'b0;
      safe_r <= 1'b0;
      out_r <= 1'b0;
      tsd_r <= 1'b0;
      pre_r <= 1'b0;
      crc_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      ref_r <= ref_fault;
      safe_r <= failsafe_mode;
      out_r <= channel_fault;
      tsd_r <= overtemp_shutdown;
      pre_r <= overtemp_warning;
      crc_r <= crc_fault;
      if (adc_done && adc_is_supply) begin
        low_r <= supply_below_thr;
      end
    end
  end

  // results only load from the converter; bus writes never reach them
  always_ff @(posedge clk) begin
    if (reset) begin
      supply_r <= ZERO_BYTE;
      conv_r   <= ZERO_BYTE;
    end else if (adc_done) begin
      if (adc_is_supply) begin
        supply_r <= adc_result;
      end else begin
        conv_r <= adc_result;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pass_r  <= ZERO_BYTE;
      sel_r   <= '0;
      start_r <= 1'b0;
    end else begin
      start_r <= wr_adcsel;
      if (wr_pass) begin
        pass_r <= reg_wdata;
      end
      if (wr_adcsel) begin
        sel_r <= reg_wdata[ADC_SEL_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  wire logic any_err = por_flag | ref_r | safe_r | out_r | tsd_r | pre_r | crc_r
                     | low_r | (|diag_flag);
  wire logic [7:0] gen_word = {1'b0, ref_r, safe_r, out_r, pre_r, tsd_r,
                               por_flag, any_err};
  wire logic [7:0] sec_word = {2'b00, pin_level, prog_flag, low_r,
                               done_flag, od_flag, crc_r};
  wire logic [7:0] diag_lo  = diag_flag[7:0];
  wire logic [7:0] diag_hi  = {4'h0, diag_flag[CHANNELS-1:8]};
  wire logic [7:0] rd_word  =
      (reg_addr == OFF_GEN_STATUS) ? gen_word :
      (reg_addr == OFF_SEC_STATUS) ? sec_word :
      (reg_addr == OFF_SUPPLY_RES) ? supply_r :
      (reg_addr == OFF_CONV_RES)   ? conv_r   :
      (reg_addr == OFF_DIAG_LOW)   ? diag_lo  :
      (reg_addr == OFF_DIAG_HIGH)  ? diag_hi  :
      (reg_addr == OFF_PASSWORD)   ? pass_r   :
      (reg_addr == OFF_ADC_SELECT) ? {3'b000, sel_r} : ZERO_BYTE;

  // clear-por reads back zero: it is a self-returning strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata  <= ZERO_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_en;
      reg_rdata  <= rd_en ? rd_word : ZERO_BYTE;
    end
  end

  assign conversion_start          = start_r;
  assign conversion_channel_select = sel_r;
  assign eeprom_password_value     = pass_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_por_hold;
    @(posedge clk) disable iff (reset) (por_flag && !clear_por) |=> por_flag;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("por flag lost");

  property p_por_clear;
    @(posedge clk) disable iff (reset) clear_por |=> !por_flag;
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("por not cleared");

  property p_err_sum;
    @(posedge clk) disable iff (reset) rd_en && reg_addr == OFF_GEN_STATUS
      && (por_flag || out_r) |=> reg_rdata[GS_ERR];
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("summary error missing");

  property p_out_follow;
    @(posedge clk) disable iff (reset) channel_fault |=> out_r;
  endproperty
  a_out_follow: assert property (p_out_follow) else $error("output fault missed");

  property p_done_set;
    @(posedge clk) disable iff (reset) adc_done |=> done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set");

  property p_done_clr;
    @(posedge clk) disable iff (reset) rd_conv && !adc_done |=> !done_flag;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");

  property p_start;
    @(posedge clk) disable iff (reset) wr_adcsel |=> conversion_start
      && conversion_channel_select == $past(reg_wdata[ADC_SEL_W-1:0]);
  endproperty
  a_start: assert property (p_start) else $error("conversion not started");

  property p_ro_write;
    @(posedge clk) disable iff (reset) wr_en && reg_addr == OFF_CONV_RES
      && !adc_done |=> $stable(conv_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("result written");

  property p_reserved;
    @(posedge clk) disable iff (reset) rd_en && reg_addr == OFF_DIAG_HIGH
      |=> reg_rdata[7:4] == 4'h0 && reg_rvalid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_sec_reserved;
    @(posedge clk) disable iff (reset) rd_en && reg_addr == OFF_SEC_STATUS
      |=> reg_rdata[7:6] == 2'b00 && reg_rvalid;
  endproperty
  a_sec_reserved: assert property (p_sec_reserved) else $error("status bits 7-6 set");

  // low-supply only follows supply conversions, general ones leave it
  property p_low_supply;
    @(posedge clk) disable iff (reset) adc_done && adc_is_supply
      |=> low_r == $past(supply_below_thr);
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("low supply flag wrong");

  property p_pass_load;
    @(posedge clk) disable iff (reset) wr_pass
      |=> eeprom_password_value == $past(reg_wdata);
  endproperty
  a_pass_load: assert property (p_pass_load) else $error("password not loaded");

endmodule
`default_nettype wire

// ### core/pin_sync.sv
// Purpose: two-flop synchroniser for an asynchronous pin
// Assumes: single bit level
// Notes:   first stage read only by second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### core/status_flags_pkg.sv
// Purpose: constants for the status and flag register bank
// Assumes: 8-bit registers on a byte-wide address/data register port
// Notes:   offsets are the device register addresses
package status_flags_pkg;
  localparam logic [7:0] OFF_CLEAR_CTRL   = 8'h60;
  localparam logic [7:0] OFF_ADC_SELECT   = 8'h62;
  localparam logic [7:0] OFF_PASSWORD     = 8'h65;
  localparam logic [7:0] OFF_GEN_STATUS   = 8'h70;
  localparam logic [7:0] OFF_SEC_STATUS   = 8'h71;
  localparam logic [7:0] OFF_SUPPLY_RES   = 8'h72;
  localparam logic [7:0] OFF_CONV_RES     = 8'h73;
  localparam logic [7:0] OFF_DIAG_LOW     = 8'h74;
  localparam logic [7:0] OFF_DIAG_HIGH    = 8'h75;
  // general status bit positions
  localparam int GS_ERR  = 0;
  localparam int GS_POR  = 1;
  localparam int GS_TSD  = 2;
  localparam int GS_PRE  = 3;
  localparam int GS_OUT  = 4;
  localparam int GS_SAFE = 5;
  localparam int GS_REF  = 6;
  // secondary status bit positions
  localparam int SS_CRC  = 0;
  localparam int SS_OD   = 1;
  localparam int SS_DONE = 2;
  localparam int SS_LOW  = 3;
  localparam int SS_PROG = 4;
  localparam int SS_PIN  = 5;
  localparam int POR_CLEAR_BIT = 0;
  localparam int ADC_SEL_W   = 5;
  localparam int CHANNELS    = 12;
  localparam logic [7:0] GEN_STATUS_RST = 8'h03;
  localparam logic [7:0] ZERO_BYTE      = 8'h00;
endpackage

// ### core/sticky_bit.sv
// Purpose: one sticky flag, set wins over clear
// Assumes: synchronous active-high reset
// Notes:   reset value is a parameter
`timescale 1ns/10ps
`default_nettype none
module sticky_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic set,
  input  wire logic clear,
  output logic      q
);
  // set beats clear so a same-cycle event is never lost
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RST_VAL;
    end else if (set) begin
      q <= 1'b1;
    end else if (clear) begin
      q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/host_model.sv
// Purpose: host side register access model
// Assumes: one-cycle strobes, read data one cycle after rd_en
// Notes:   released lines show inverted value so stale data cannot pass
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            wr_en,
  output logic            rd_en,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // ------------------------------------------------
  // access tasks
  // ------------------------------------------------
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
  end
  // password and channel select writes go through here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    wr_en     <= 1'b1;
    @(posedge clk);
    wr_en     <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // no valid strobe gives unknown data, so a missing answer never matches
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    rd_en    <= 1'b1;
    @(posedge clk);
    rd_en    <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ### tb/led_driver_status_flags_tb.sv
// Purpose: self-checking bench for the status flag bank
// Assumes: host model drives the register port
// Notes:   live inputs ordered ref, fail-safe, output, warning, shutdown
`timescale 1ns/10ps
`default_nettype none
module led_driver_status_flags_tb;
  import status_flags_pkg::*;
  logic        clk, reset, pin, crc, sup, below;
  logic [4:0]  live, ev;
  logic [7:0]  res, addr, wdata, rdata, pw;
  logic [11:0] dopen, dshort, dss;
  logic        wr, rd, rvalid, cstart;
  logic [4:0]  csel;
  int          mismatches = 0;
  int          checks = 0;

  host_model u_host_model (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .wr_en(wr),
    .rd_en(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
  led_driver_status_flags u_led_driver_status_flags (.clk(clk), .reset(reset),
    .reg_addr(addr), .reg_wdata(wdata), .wr_en(wr), .rd_en(rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .failsafe_input_pin(pin), .ref_fault(live[4]),
    .failsafe_mode(live[3]), .channel_fault(live[2]), .overtemp_warning(live[1]),
    .overtemp_shutdown(live[0]), .crc_fault(crc), .eeprom_prog_start(ev[0]),
    .eeprom_prog_done(ev[1]), .adc_done(ev[2]), .diag_start(ev[3]), .diag_done(ev[4]),
    .adc_result(res), .adc_is_supply(sup), .supply_below_thr(below), .diag_open(dopen),
    .diag_short(dshort), .diag_single_short(dss), .conversion_start(cstart),
    .conversion_channel_select(csel), .eeprom_password_value(pw));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host_model.rd(a, d);
    cmp(d, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic adc(input logic [7:0] r, input logic s, input logic b);
    @(posedge clk);
    res   <= r;
    sup   <= s;
    below <= b;
    pulse(2);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // whole run is under two hundred cycles
  initial begin
    #(40 * 4000);
    mismatches++;
    stop_test();
  end

  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial begin
    {reset, pin, crc, sup, below, live, ev, res} = {1'b1, 22'h0};
    {dopen, dshort, dss} = 36'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rc(OFF_GEN_STATUS, GEN_STATUS_RST);
    rc(OFF_SEC_STATUS, ZERO_BYTE);
    rc(OFF_CONV_RES, ZERO_BYTE);
    rc(OFF_DIAG_LOW, ZERO_BYTE);
    rc(OFF_PASSWORD, ZERO_BYTE);
    for (int a = 'h70; a <= 'h75; a++) u_host_model.wr(8'(a), 8'hFF);
    rc(OFF_GEN_STATUS, GEN_STATUS_RST);
    rc(OFF_DIAG_HIGH, ZERO_BYTE);
    u_host_model.wr(OFF_CLEAR_CTRL, 8'h01);
    rc(OFF_GEN_STATUS, ZERO_BYTE);
    rc(OFF_CLEAR_CTRL, ZERO_BYTE);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      live <= 5'(1 << i);
      repeat (2) @(posedge clk);
      rc(OFF_GEN_STATUS, {1'b0, 5'(1 << i), 2'b01});
    end
    @(posedge clk);
    live <= 5'h00;
    crc  <= 1'b1;
    repeat (2) @(posedge clk);
    rc(OFF_SEC_STATUS, 8'h01);
    @(posedge clk);
    crc <= 1'b0;
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    rc(OFF_SEC_STATUS, 8'h20);
    @(posedge clk);
    pin <= 1'b0;
    $display("test live done");
    u_host_model.wr(OFF_ADC_SELECT, 8'h05);
    cmp({2'b00, cstart, csel}, 8'h25);
    adc(8'h33, 1'b1, 1'b1);
    rc(OFF_SUPPLY_RES, 8'h33);
    rc(OFF_SEC_STATUS, 8'h0C);
    adc(8'h5A, 1'b0, 1'b0);
    rc(OFF_CONV_RES, 8'h5A);
    rc(OFF_SEC_STATUS, 8'h08);
    rc(OFF_GEN_STATUS, 8'h01);
    $display("test adc done");
    pulse(3);
    @(posedge clk);
    {dopen, dshort, dss} <= {12'h001, 12'h200, 12'h020};
    @(posedge clk);
    {dopen, dshort, dss} <= 36'h0;
    pulse(4);
    rc(OFF_DIAG_LOW, 8'h21);
    rc(OFF_DIAG_HIGH, 8'h02);
    rc(OFF_SEC_STATUS, 8'h0A);
    pulse(0);
    rc(OFF_SEC_STATUS, 8'h0A);
    pulse(1);
    rc(OFF_SEC_STATUS, 8'h1A);
    u_host_model.wr(OFF_PASSWORD, 8'hA5);
    rc(OFF_PASSWORD, 8'hA5);
    cmp(pw, 8'hA5);
    $display("test misc done");
    adc(8'hC8, 1'b1, 1'b0);
    rc(OFF_SEC_STATUS, 8'h16);
    rc(OFF_SUPPLY_RES, 8'hC8);
    pulse(3);
    rc(OFF_DIAG_LOW, ZERO_BYTE);
    rc(OFF_SEC_STATUS, 8'h14);
    rc(OFF_GEN_STATUS, ZERO_BYTE);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rc(OFF_GEN_STATUS, GEN_STATUS_RST);
    rc(OFF_PASSWORD, ZERO_BYTE);
    cmp(pw, ZERO_BYTE);
    $display("test clear done");
    stop_test();
  end
endmodule
`default_nettype wire
